// File: rtl/amst_params.svh
`ifndef AMST_PARAMS_SVH
`define AMST_PARAMS_SVH

// wait extension granularity: each wait block stretches the strobe by this many clocks
`define AMST_WAIT_BLOCK_CYCLES 16
// least lead of the wait input before the nominal end of the strobe phase
`define AMST_WAIT_LEAD_CYCLES 4
// least width of each wait level
`define AMST_WAIT_LEVEL_CYCLES 2
// reset levels of the memory-side strobes (active low, so idle high)
`define AMST_STROBE_IDLE 1'b1
// default field widths
`define AMST_SETUP_W 4
`define AMST_STROBE_W 6
`define AMST_HOLD_W 3
`define AMST_TURN_W 2
`define AMST_MAXWAIT_W 8
`define AMST_ADDR_W 21
`define AMST_DATA_W 16
`define AMST_CS_W 4

`endif

// File: rtl/amst_pkg.sv
package amst_pkg;

	// access sequencer states
	typedef enum logic [2:0]
	{
		AMST_IDLE = 3'b000,
		AMST_SETUP = 3'b001,
		AMST_STROBE = 3'b010,
		AMST_STRETCH = 3'b011,
		AMST_HOLD = 3'b100,
		AMST_TURN = 3'b101
	} amst_state_t;

endpackage

// File: rtl/amst_async_memory_strobe_timing.sv
`timescale 1ns/1ps
`include "amst_params.svh"
// Functional notes
// - every phase is timed in whole clock cycles, a programmed count giving that many cycles; a zero setup, strobe or hold count still takes one.
// - without extended wait, a read lasts exactly setup plus strobe plus hold cycles.
// - with extended wait, the strobe, and so the access, stretches in blocks of sixteen cycles, one more block while the synchronised wait stays high.
// - in select-strobe mode chip select falls with the strobe, otherwise a setup count earlier.
// - without select-strobe mode chip select stays low a hold count after the strobe rises, else both rise together.
// - read data is captured at the clock edge where the read strobe rises, ending the strobe phase.
// - turnaround, read and write setup, strobe and hold, and the wait limit are programmable inputs.
// - extended waiting stops with a timeout once the programmed wait count is reached.
module amst_async_memory_strobe_timing
#(
	parameter int SETUP_W = `AMST_SETUP_W,
	parameter int STROBE_W = `AMST_STROBE_W,
	parameter int HOLD_W = `AMST_HOLD_W,
	parameter int TURN_W = `AMST_TURN_W,
	parameter int MAXWAIT_W = `AMST_MAXWAIT_W,
	parameter int ADDR_W = `AMST_ADDR_W,
	parameter int DATA_W = `AMST_DATA_W,
	parameter int CS_W = `AMST_CS_W
)
(
	input wire logic clock,
	input wire logic rst,
	// access request side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [CS_W-1:0] req_select,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	output logic [DATA_W-1:0] rd_data,
	output logic access_done,
	output logic wait_timeout,
	output logic access_busy,
	// configuration
	input wire logic [TURN_W-1:0] turnaround_cycles,
	input wire logic [SETUP_W-1:0] read_setup_cycles,
	input wire logic [STROBE_W-1:0] read_strobe_cycles,
	input wire logic [HOLD_W-1:0] read_hold_cycles,
	input wire logic [SETUP_W-1:0] write_setup_cycles,
	input wire logic [STROBE_W-1:0] write_strobe_cycles,
	input wire logic [HOLD_W-1:0] write_hold_cycles,
	input wire logic [MAXWAIT_W-1:0] max_wait_count,
	input wire logic extended_wait_enable,
	input wire logic select_strobe_mode,
	// memory pins
	output logic [CS_W-1:0] async_chip_select_n,
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic [ADDR_W-1:0] memory_addr,
	output logic [DATA_W-1:0] memory_data_out,
	output logic memory_data_oe,
	input wire logic [DATA_W-1:0] memory_data_bus,
	input wire logic memory_wait_in
);

	localparam int CNT_W = (STROBE_W > 5) ? STROBE_W : 5;
	localparam logic [CNT_W-1:0] BLOCK_LOAD = CNT_W'(`AMST_WAIT_BLOCK_CYCLES - 1);

	// counter load for a phase of v cycles; a zero count still takes one cycle
	function automatic logic [CNT_W-1:0] phase_load(input logic [CNT_W-1:0] v);
		phase_load = (v == '0) ? '0 : v - 1'b1;
	endfunction

	amst_pkg::amst_state_t state;
	amst_pkg::amst_state_t next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [MAXWAIT_W-1:0] wait_blocks;
	logic [MAXWAIT_W-1:0] next_wait_blocks;
	logic wr;
	logic [CS_W-1:0] sel;
	logic wait_meta;
	logic wait_sync;
	logic wait_seen;
	logic timeout_hit;

	// selected timing for the access in progress
	wire logic [CNT_W-1:0] setup_len = wr ? CNT_W'(write_setup_cycles) : CNT_W'(read_setup_cycles);
	wire logic [CNT_W-1:0] strobe_len = wr ? CNT_W'(write_strobe_cycles) : CNT_W'(read_strobe_cycles);
	wire logic [CNT_W-1:0] hold_len = wr ? CNT_W'(write_hold_cycles) : CNT_W'(read_hold_cycles);
	wire logic cnt_end = (cnt == '0);
	wire logic take = (state == amst_pkg::AMST_IDLE) && req_valid;
	// the pins load on the accepting edge too, before sel and wr hold the new request
	wire logic [CS_W-1:0] cur_sel = take ? req_select : sel;
	wire logic cur_wr = take ? req_write : wr;
	wire logic wait_req = extended_wait_enable && (wait_seen || wait_sync);
	wire logic more_wait = wait_sync && (wait_blocks < max_wait_count);
	wire logic next_strobe = (next_state == amst_pkg::AMST_STROBE) || (next_state == amst_pkg::AMST_STRETCH);
	wire logic next_active = (next_state == amst_pkg::AMST_SETUP) || next_strobe || (next_state == amst_pkg::AMST_HOLD);
	wire logic strobe_end = ((state == amst_pkg::AMST_STROBE) || (state == amst_pkg::AMST_STRETCH))
		&& (next_state == amst_pkg::AMST_HOLD);

	assign req_ready = (state == amst_pkg::AMST_IDLE);
	assign access_busy = !req_ready;

	// phase sequencer
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_wait_blocks = wait_blocks;
		timeout_hit = 1'b0;
		unique case (state)
			amst_pkg::AMST_IDLE:
			begin
				if (req_valid)
				begin
					next_state = amst_pkg::AMST_SETUP;
					next_cnt = phase_load(req_write ? CNT_W'(write_setup_cycles) : CNT_W'(read_setup_cycles));
				end
			end
			amst_pkg::AMST_SETUP:
			begin
				if (cnt_end)
				begin
					next_state = amst_pkg::AMST_STROBE;
					next_cnt = phase_load(strobe_len);
				end
				else
					next_cnt = cnt - 1'b1;
			end
			amst_pkg::AMST_STROBE:
			begin
				if (!cnt_end)
					next_cnt = cnt - 1'b1;
				else if (wait_req && (max_wait_count != '0))
				begin
					next_state = amst_pkg::AMST_STRETCH;
					next_cnt = BLOCK_LOAD;
					next_wait_blocks = MAXWAIT_W'(1);
				end
				else
				begin
					next_state = amst_pkg::AMST_HOLD;
					next_cnt = phase_load(hold_len);
					timeout_hit = wait_req;
				end
			end
			amst_pkg::AMST_STRETCH:
			begin
				if (!cnt_end)
					next_cnt = cnt - 1'b1;
				else if (more_wait)
				begin
					next_cnt = BLOCK_LOAD;
					next_wait_blocks = wait_blocks + 1'b1;
				end
				else
				begin
					next_state = amst_pkg::AMST_HOLD;
					next_cnt = phase_load(hold_len);
					timeout_hit = wait_sync;
				end
			end
			amst_pkg::AMST_HOLD:
			begin
				if (!cnt_end)
					next_cnt = cnt - 1'b1;
				else if (turnaround_cycles != '0)
				begin
					next_state = amst_pkg::AMST_TURN;
					next_cnt = phase_load(CNT_W'(turnaround_cycles));
				end
				else
					next_state = amst_pkg::AMST_IDLE;
			end
			amst_pkg::AMST_TURN:
			begin
				if (cnt_end)
					next_state = amst_pkg::AMST_IDLE;
				else
					next_cnt = cnt - 1'b1;
			end
			default:
				next_state = amst_pkg::AMST_IDLE;
		endcase
	end

	// state, counters and latched request
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state <= amst_pkg::AMST_IDLE;
			cnt <= '0;
			wait_blocks <= '0;
			wr <= 1'b0;
			sel <= '0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			wait_blocks <= next_wait_blocks;
			if (take)
			begin
				wr <= req_write;
				sel <= req_select;
			end
		end
	end

	// wait input synchroniser and strobe-phase wait latch
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wait_meta <= 1'b0;
			wait_sync <= 1'b0;
			wait_seen <= 1'b0;
		end
		else
		begin
			wait_meta <= memory_wait_in;
			wait_sync <= wait_meta;
			if (state == amst_pkg::AMST_SETUP)
				wait_seen <= 1'b0;
			else if (state == amst_pkg::AMST_STROBE && wait_sync)
				wait_seen <= 1'b1;
		end
	end

	// memory pins registered from the next state so each phase edge is clean
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			async_chip_select_n <= {CS_W{`AMST_STROBE_IDLE}};
			read_strobe_n <= `AMST_STROBE_IDLE;
			write_strobe_n <= `AMST_STROBE_IDLE;
			memory_data_oe <= 1'b0;
		end
		else
		begin
			if (select_strobe_mode ? next_strobe : next_active)
				async_chip_select_n <= ~cur_sel;
			else
				async_chip_select_n <= {CS_W{`AMST_STROBE_IDLE}};
			read_strobe_n <= !(next_strobe && !wr);
			write_strobe_n <= !(next_strobe && wr);
			memory_data_oe <= next_active && cur_wr;
		end
	end

	// address and write data latched at acceptance and held to hold end
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			memory_addr <= '0;
			memory_data_out <= '0;
		end
		else if (take)
		begin
			memory_addr <= req_addr;
			memory_data_out <= req_wdata;
		end
	end

	// read capture and completion pulses
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rd_data <= '0;
			access_done <= 1'b0;
			wait_timeout <= 1'b0;
		end
		else
		begin
			if (strobe_end && !wr)
				rd_data <= memory_data_bus;
			access_done <= (state == amst_pkg::AMST_HOLD) && cnt_end;
			wait_timeout <= timeout_hit;
		end
	end

endmodule // amst_async_memory_strobe_timing

// File: sim/amst_async_memory_strobe_timing_props.sv
`timescale 1ns/1ps
module amst_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic req_ready,
	input wire logic [3:0] async_chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [20:0] memory_addr,
	input wire logic [3:0] read_setup_cycles,
	input wire logic [5:0] read_strobe_cycles,
	input wire logic extended_wait_enable,
	input wire logic select_strobe_mode
);
	logic [9:0] low_n;
	logic [9:0] lead_n;
	wire [9:0] s_exp = (read_setup_cycles == 4'h0) ? 10'h001 : {6'h00, read_setup_cycles};
	wire cs_on = ~&async_chip_select_n;
	wire [9:0] t_exp = (read_strobe_cycles == 6'h00) ? 10'h001 : {4'h0, read_strobe_cycles};
	// counts cycles with the read strobe low
	always_ff @(posedge clock)
	begin
		if (rst || read_strobe_n)
			low_n <= 10'h000;
		else
			low_n <= low_n + 10'h001;
	end
	// counts cycles with select on and the read strobe still high
	always_ff @(posedge clock)
	begin
		if (rst || !cs_on)
			lead_n <= 10'h000;
		else if (read_strobe_n)
			lead_n <= lead_n + 10'h001;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_strobe_width: assert property ($rose(read_strobe_n) && !extended_wait_enable |-> low_n == t_exp)
		else $error("read strobe width");
	chk_cs_lead: assert property ($fell(read_strobe_n) && !select_strobe_mode |-> $past(cs_on))
		else $error("select not ahead");
	chk_cs_setup: assert property ($fell(read_strobe_n) && !select_strobe_mode |-> lead_n == s_exp)
		else $error("select lead length");
	chk_cs_with: assert property ($fell(read_strobe_n) && select_strobe_mode |-> cs_on && !$past(cs_on))
		else $error("select not with strobe");
	chk_cs_hold: assert property ($rose(read_strobe_n) && !select_strobe_mode |-> cs_on)
		else $error("select hold lost");
	chk_cs_free: assert property ($rose(read_strobe_n) && select_strobe_mode |-> !cs_on)
		else $error("select late");
	chk_addr_steady: assert property (cs_on && $past(cs_on) |-> $stable(memory_addr))
		else $error("address moved");
	chk_idle_quiet: assert property (req_ready |-> read_strobe_n && write_strobe_n && !cs_on)
		else $error("strobe while idle");
	chk_write_setup: assert property ($fell(write_strobe_n) && !select_strobe_mode |-> $past(cs_on))
		else $error("write before setup");
endmodule // amst_props
bind amst_async_memory_strobe_timing amst_props u_chk (.clock, .rst, .req_ready, .async_chip_select_n,
	.read_strobe_n, .write_strobe_n, .memory_addr, .read_setup_cycles, .read_strobe_cycles, .extended_wait_enable,
	.select_strobe_mode);

// File: sim/amst_mem_model.sv
`timescale 1ns/1ps
module amst_mem_model (
	input wire logic clock,
	input wire logic [3:0] async_chip_select_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [20:0] memory_addr,
	input wire logic [15:0] memory_data_out,
	input wire logic [7:0] wait_len,
	output logic [15:0] memory_data_bus,
	output logic memory_wait_in
);
	logic [15:0] mem [0:15];
	logic [15:0] bus_q = 16'h0000;
	logic [7:0] wc = 8'h00;
	logic strobe_q = 1'b0;
	wire strobe = ~&async_chip_select_n && !(read_strobe_n && write_strobe_n);
	assign memory_data_bus = bus_q;
	// wait stays up wait_len cycles, none in the first two rows and ten or more in the others
	assign memory_wait_in = wc != 8'h00;
	// stores writes, answers reads, toggles a released bus, raises wait at strobe start
	always @(posedge clock)
	begin
		strobe_q <= strobe;
		if (strobe && !write_strobe_n)
			mem[memory_addr[3:0]] <= memory_data_out;
		bus_q <= (strobe && !read_strobe_n) ? mem[memory_addr[3:0]] : ~bus_q;
		wc <= (strobe && !strobe_q) ? wait_len : wc - {7'h00, wc != 8'h00};
	end
endmodule // amst_mem_model

// File: sim/test_async_memory_strobe_timing.sv
`timescale 1ns/1ps
module test_async_memory_strobe_timing;
	typedef struct {logic s; logic e; int su; int st; int hd; int ta; int wl; int mw; int b; logic to;} amst_row_t;
	amst_row_t rows [6] = '{'{0, 0, 1, 2, 1, 0, 0, 0, 0, 0}, '{1, 0, 0, 63, 7, 3, 0, 0, 0, 0},
		'{0, 0, 2, 8, 2, 1, 10, 4, 0, 0}, '{0, 1, 2, 8, 2, 1, 10, 4, 1, 0},
		'{0, 1, 1, 8, 1, 2, 30, 4, 2, 0}, '{1, 1, 1, 8, 1, 0, 40, 1, 1, 1}};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic select_strobe_mode = 1'b0;
	logic extended_wait_enable = 1'b0;
	logic [3:0] req_select = 4'h0;
	logic [20:0] req_addr = 21'h000000;
	logic [15:0] req_wdata = 16'h0000;
	logic [1:0] turnaround_cycles = 2'h0;
	logic [3:0] read_setup_cycles = 4'h1;
	logic [5:0] read_strobe_cycles = 6'h02;
	logic [2:0] read_hold_cycles = 3'h1;
	logic [7:0] max_wait_count = 8'h00;
	logic [7:0] wait_len = 8'h00;
	logic req_ready, access_done, wait_timeout, read_strobe_n, write_strobe_n, memory_wait_in;
	logic [3:0] async_chip_select_n;
	logic [20:0] memory_addr;
	logic [15:0] rd_data, memory_data_out, memory_data_bus;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	int e;
	amst_async_memory_strobe_timing uut (.clock, .rst, .req_valid, .req_ready, .req_write, .req_select, .req_addr,
		.req_wdata, .rd_data, .access_done, .wait_timeout, .access_busy(), .turnaround_cycles, .read_setup_cycles,
		.read_strobe_cycles, .read_hold_cycles, .write_setup_cycles(read_setup_cycles),
		.write_strobe_cycles(read_strobe_cycles), .write_hold_cycles(read_hold_cycles), .max_wait_count,
		.extended_wait_enable, .select_strobe_mode, .async_chip_select_n, .read_strobe_n, .write_strobe_n,
		.memory_addr, .memory_data_out, .memory_data_oe(), .memory_data_bus, .memory_wait_in);
	amst_mem_model mem (.clock, .async_chip_select_n, .read_strobe_n, .write_strobe_n, .memory_addr,
		.memory_data_out, .wait_len, .memory_data_bus, .memory_wait_in);
	initial forever #2 clock = ~clock;
	task tick;
		@(posedge clock);
		#1;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// one access: request, count cycles to done, note selects and timeout, then wait for ready
	task acc(input logic w, input int i);
		int n;
		logic [3:0] seen;
		logic to;
		seen = 4'h0;
		to = 1'b0;
		@(posedge clock);
		req_valid <= 1'b1;
		req_write <= w;
		req_select <= 4'h1 << i[1:0];
		req_addr <= i[20:0];
		req_wdata <= 16'ha500 + i[15:0];
		@(posedge clock);
		req_valid <= 1'b0;
		#1;
		for (n = 0; access_done !== 1'b1 && n < 500; n++)
		begin
			tick;
			seen = seen | ~async_chip_select_n;
			to = to | wait_timeout;
		end
		cmp(n, e);
		cmp(seen, 4'h1 << i[1:0]);
		cmp(to, rows[i].to);
		if (!w)
			cmp(rd_data, 16'ha500 + i[15:0]);
		for (n = 0; req_ready !== 1'b1 && n < 20; n++)
			tick;
		cmp(n, rows[i].ta);
	endtask
	// hang guard
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			finish_test;
		end
	end
	// each row: write then read back under one timing setup
	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clock);
			select_strobe_mode <= rows[i].s;
			extended_wait_enable <= rows[i].e;
			read_setup_cycles <= rows[i].su[3:0];
			read_strobe_cycles <= rows[i].st[5:0];
			read_hold_cycles <= rows[i].hd[2:0];
			turnaround_cycles <= rows[i].ta[1:0];
			wait_len <= rows[i].wl[7:0];
			max_wait_count <= rows[i].mw[7:0];
			e = (rows[i].su == 0 ? 1 : rows[i].su) + rows[i].st + rows[i].hd + 16 * rows[i].b;
			acc(1'b1, i);
			acc(1'b0, i);
			$display("test %0d done", i);
		end
		finish_test;
	end
endmodule // test_async_memory_strobe_timing
